//--- hdl/smrc_consts.svh
// Timing counts, encodings and pin positions for the sleep and reset controller
`ifndef SMRC_CONSTS_SVH
`define SMRC_CONSTS_SVH

`define SMRC_CLK_PERIOD_NS 10
`define SMRC_RST_MIN_NS 500
`define SMRC_RST_CYCLES ((`SMRC_RST_MIN_NS + `SMRC_CLK_PERIOD_NS - 1) / `SMRC_CLK_PERIOD_NS)
`define SMRC_RST_CNT_W 7

`define SMRC_MODE_W 3
`define SMRC_MODE_IDLE 3'h0
`define SMRC_MODE_ADC_NR 3'h1
`define SMRC_MODE_PWR_DOWN 3'h2
`define SMRC_MODE_PWR_SAVE 3'h3
`define SMRC_MODE_STANDBY 3'h6
`define SMRC_MODE_EXT_STANDBY 3'h7

`define SMRC_PORT_W 32
`define SMRC_TCK_BIT 18
`define SMRC_TMS_BIT 19
`define SMRC_TDI_BIT 21

`endif

//--- hdl/smrc_pkg.sv
// Types shared by the sleep and reset controller
package smrc_pkg;
    // Clock and oscillator enables handed to the gated domains
    typedef struct packed {
        logic cpu;
        logic io;
        logic adc;
        logic async_tmr;
        logic osc;
    } smrc_gates_t;

    // Sleep sequencer states
    typedef enum logic [1:0] {
        SMRC_RUN,
        SMRC_SLEEP,
        SMRC_WAKE
    } smrc_state_t;
endpackage

//--- hdl/smrc_reset_filter.sv
// Pulse-width filter for the external active-low reset pin
`timescale 1ns/100ps
`include "smrc_consts.svh"
module smrc_reset_filter #(
    parameter int CYCLES = `SMRC_RST_CYCLES,
    parameter int CNT_W = `SMRC_RST_CNT_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin_n,
    output logic reset
);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic next_reset;

    // Count low samples; short glitches restart the count and never reset the chip
    always_comb begin
        next_cnt = cnt;
        next_reset = reset;
        if (pin_n) begin
            next_cnt = '0;
            next_reset = 1'b0;
        end else if (cnt == CNT_W'(CYCLES)) begin
            next_reset = 1'b1;
        end else begin
            next_cnt = cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            reset <= 1'b0;
        end else begin
            cnt <= next_cnt;
            reset <= next_reset;
        end
    end
endmodule

//--- hdl/smrc_top.sv
// Sleep-mode sequencer, clock gating and reset control for the microcontroller core
// Contract
// - Six software-selected sleep modes: idle, ADC noise, power-down, power-save, standby, extended.
// - Idle stops CPU clock; SRAM, timers, SPI and interrupts keep running.
// - Power-down stops oscillator, keeps registers; only interrupt or reset wakes.
// - Power-save keeps the asynchronous timer counting for a time base.
// - ADC noise mode stops CPU and I/O except async timer and converter.
// - Standby keeps the main oscillator running, everything else asleep.
// - Extended standby keeps main oscillator and asynchronous timer running.
// - Reset pin low over 500 ns resets; shorter pulses are not guaranteed.
// - During reset every port pin is tri-stated, even without a clock.
// - With test port enabled, TDI, TMS, TCK pull-ups stay on through reset.
`timescale 1ns/100ps
`include "smrc_consts.svh"
module smrc_top #(
    parameter int PORT_W = `SMRC_PORT_W,
    parameter int RST_CYCLES = `SMRC_RST_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ext_reset_n,
    input wire logic sleep_enable,
    input wire logic [`SMRC_MODE_W-1:0] sleep_mode,
    input wire logic sleep_req,
    input wire logic wake_irq,
    input wire logic jtag_enable,
    input wire logic [PORT_W-1:0] port_oe_req,
    input wire logic [PORT_W-1:0] port_pullup_req,
    output logic [PORT_W-1:0] port_oe,
    output logic [PORT_W-1:0] port_pullup,
    output smrc_pkg::smrc_gates_t gates,
    output logic cpu_run,
    output logic sleeping,
    output logic [`SMRC_MODE_W-1:0] active_mode,
    output logic core_reset_n
);
    import smrc_pkg::*;

    logic rst_meta;
    logic rst_sync_n;
    logic pin_reset;
    logic in_reset;
    logic mode_ok;
    logic [PORT_W-1:0] jtag_pull_mask;
    smrc_state_t state;
    smrc_state_t next_state;
    logic [`SMRC_MODE_W-1:0] next_active_mode;
    smrc_gates_t next_gates;
    logic next_cpu_run;
    logic drive_cut;

    // Clock enable patterns {cpu, io, adc, async_tmr, osc}, one per state or sleep mode;
    // power-down clears every enable, the sequencer itself keeps running on the free clock
    localparam smrc_gates_t GATES_RUN = '{cpu: 1'b1, io: 1'b1, adc: 1'b1, async_tmr: 1'b1, osc: 1'b1};
    localparam smrc_gates_t GATES_IDLE = '{cpu: 1'b0, io: 1'b1, adc: 1'b1, async_tmr: 1'b1, osc: 1'b1};
    localparam smrc_gates_t GATES_ADC_NR = '{cpu: 1'b0, io: 1'b0, adc: 1'b1, async_tmr: 1'b1, osc: 1'b1};
    localparam smrc_gates_t GATES_PWR_DOWN = '{cpu: 1'b0, io: 1'b0, adc: 1'b0, async_tmr: 1'b0, osc: 1'b0};
    localparam smrc_gates_t GATES_PWR_SAVE = '{cpu: 1'b0, io: 1'b0, adc: 1'b0, async_tmr: 1'b1, osc: 1'b0};
    localparam smrc_gates_t GATES_STANDBY = '{cpu: 1'b0, io: 1'b0, adc: 1'b0, async_tmr: 1'b0, osc: 1'b1};
    localparam smrc_gates_t GATES_EXT_STANDBY = '{cpu: 1'b0, io: 1'b0, adc: 1'b0, async_tmr: 1'b1, osc: 1'b1};

    // Release of the system reset passes through two flops; assertion stays asynchronous
    // A raw release near an edge could free some flops a cycle before others
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // Width filter on the external reset pin
    // The pin is taken as synchronous to clk, so no synchroniser stands in front
    smrc_reset_filter #(
        .CYCLES(RST_CYCLES),
        .CNT_W(`SMRC_RST_CNT_W)
    ) u_filter (
        .clk(clk),
        .rst_n(rst_sync_n),
        .pin_n(ext_reset_n),
        .reset(pin_reset)
    );

    // Core reset covers both the system reset and a qualified pin reset
    // The filtered path needs a clock; the raw pin term below covers the clockless case
    assign in_reset = pin_reset | ~rst_sync_n;
    assign core_reset_n = ~in_reset;

    // Drivers are cut combinationally from the raw pin and raw reset so no clock is needed;
    // a pin pulse too short to reset still tri-states for its duration, which is harmless.
    assign drive_cut = in_reset | ~ext_reset_n | ~arst_n;
    assign port_oe = drive_cut ? '0 : port_oe_req;

    // Test port pull-ups survive reset; other pull-ups drop with the drivers
    // so an attached debugger still sees defined test pins while the core is held
    always_comb begin
        jtag_pull_mask = '0;
        jtag_pull_mask[`SMRC_TCK_BIT] = jtag_enable;
        jtag_pull_mask[`SMRC_TMS_BIT] = jtag_enable;
        jtag_pull_mask[`SMRC_TDI_BIT] = jtag_enable;
    end
    assign port_pullup = (drive_cut ? '0 : port_pullup_req) | jtag_pull_mask;

    // Only the six defined encodings start a sleep; others are ignored
    // Codes 4 and 5 are reserved and dropped rather than mapped to a guess
    always_comb begin
        case (sleep_mode)
            `SMRC_MODE_IDLE,
            `SMRC_MODE_ADC_NR,
            `SMRC_MODE_PWR_DOWN,
            `SMRC_MODE_PWR_SAVE,
            `SMRC_MODE_STANDBY,
            `SMRC_MODE_EXT_STANDBY: mode_ok = 1'b1;
            default: mode_ok = 1'b0;
        endcase
    end

    // Sequencer: run, sleep in the latched mode, one wake cycle with clocks back before the CPU
    // Sleep entry needs run, enable and a defined code in the same cycle
    // Wake requests count only while asleep; in run or wake they have no effect
    always_comb begin
        next_state = state;
        next_active_mode = active_mode;
        case (state)
            SMRC_RUN: begin
                if (sleep_req && sleep_enable && mode_ok) begin
                    next_state = SMRC_SLEEP;
                    next_active_mode = sleep_mode;
                end
            end
            SMRC_SLEEP: begin
                if (wake_irq) begin
                    next_state = SMRC_WAKE;
                end
            end
            SMRC_WAKE: begin
                next_state = SMRC_RUN;
            end
            default: begin
                next_state = SMRC_RUN;
            end
        endcase
        // A qualified pin reset overrides any transition and drops the latched mode;
        // the gates then come up with the run pattern on the same edge
        if (pin_reset) begin
            next_state = SMRC_RUN;
            next_active_mode = `SMRC_MODE_IDLE;
        end
    end

    // Clock gate pattern for each mode, computed from the next state so gates are registered
    // Enables come from flops so the gated domains never see a glitch on them
    always_comb begin
        next_gates = GATES_RUN;
        next_cpu_run = 1'b0;
        case (next_state)
            SMRC_RUN: begin
                next_cpu_run = 1'b1;
            end
            SMRC_WAKE: begin
                next_cpu_run = 1'b0;
            end
            SMRC_SLEEP: begin
                // Only the latched mode matters; a new select while asleep is ignored
                case (next_active_mode)
                    `SMRC_MODE_IDLE: begin
                        next_gates = GATES_IDLE;
                    end
                    `SMRC_MODE_ADC_NR: begin
                        next_gates = GATES_ADC_NR;
                    end
                    `SMRC_MODE_PWR_DOWN: begin
                        next_gates = GATES_PWR_DOWN;
                    end
                    `SMRC_MODE_PWR_SAVE: begin
                        next_gates = GATES_PWR_SAVE;
                    end
                    `SMRC_MODE_STANDBY: begin
                        next_gates = GATES_STANDBY;
                    end
                    `SMRC_MODE_EXT_STANDBY: begin
                        next_gates = GATES_EXT_STANDBY;
                    end
                    default: begin
                        next_gates = GATES_IDLE; // Reserved codes never latch
                    end
                endcase
            end
            default: begin
                next_cpu_run = 1'b1;
            end
        endcase
    end

    // Sequencer state and latched mode; a system reset returns to run
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= SMRC_RUN;
            active_mode <= `SMRC_MODE_IDLE;
        end else begin
            state <= next_state;
            active_mode <= next_active_mode;
        end
    end

    // Clock enables and run flag; reset leaves every clock on, the CPU is held by core_reset_n
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            gates <= GATES_RUN;
            cpu_run <= 1'b1;
        end else begin
            gates <= next_gates;
            cpu_run <= next_cpu_run;
        end
    end

    // Sleep indication decoded straight from the state register
    assign sleeping = (state == SMRC_SLEEP);
endmodule

//--- bench/smrc_top_chk.sv
// Port-level checker for the sleep and reset controller
`timescale 1ns/100ps
`include "smrc_consts.svh"
module smrc_top_chk #(
    parameter int PORT_W = `SMRC_PORT_W,
    parameter int RST_CYCLES = `SMRC_RST_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ext_reset_n,
    input wire logic sleep_enable,
    input wire logic [`SMRC_MODE_W-1:0] sleep_mode,
    input wire logic sleep_req,
    input wire logic wake_irq,
    input wire logic jtag_enable,
    input wire logic [PORT_W-1:0] port_oe,
    input wire logic [PORT_W-1:0] port_pullup,
    input wire smrc_pkg::smrc_gates_t gates,
    input wire logic cpu_run,
    input wire logic sleeping,
    input wire logic [`SMRC_MODE_W-1:0] active_mode,
    input wire logic core_reset_n
);
    import smrc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    int low_cnt;
    int next_low_cnt;
    logic run_idle;
    // Consecutive low samples of the pin, the filter's own notion of pulse width
    always_comb next_low_cnt = ext_reset_n ? 0 : low_cnt + 1;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) low_cnt <= 0;
        else low_cnt <= next_low_cnt;
    end
    // Ready to take a sleep request: running, out of reset, pin released
    assign run_idle = cpu_run && !sleeping && core_reset_n && ext_reset_n;
    sequence s_wake;
        gates == 5'h1f && !cpu_run && !sleeping ##1 cpu_run;
    endsequence
    sleep_entry_a: assert property (run_idle && sleep_req && sleep_enable
        && sleep_mode inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7}
        |=> sleeping && !cpu_run && active_mode == $past(sleep_mode)) else $error("sleep entry missed");
    sleep_refuse_a: assert property (run_idle && sleep_req
        && (!sleep_enable || sleep_mode inside {3'h4, 3'h5}) |=> !sleeping) else $error("bad sleep taken");
    wake_order_a: assert property (sleeping && wake_irq && ext_reset_n |=> s_wake) else $error("wake order wrong");
    idle_gates_a: assert property (sleeping && active_mode == 3'h0 |-> gates == 5'h0f) else $error("idle");
    adc_gates_a: assert property (sleeping && active_mode == 3'h1 |-> gates == 5'h07) else $error("adc");
    pdown_gates_a: assert property (sleeping && active_mode == 3'h2 |-> gates == 5'h00) else $error("pd");
    psave_gates_a: assert property (sleeping && active_mode == 3'h3 |-> gates == 5'h02) else $error("ps");
    stby_gates_a: assert property (sleeping && active_mode == 3'h6 |-> gates == 5'h01) else $error("sb");
    ext_stby_a: assert property (sleeping && active_mode == 3'h7 |-> gates == 5'h03) else $error("esb");
    long_pulse_a: assert property (low_cnt > RST_CYCLES |-> !core_reset_n) else $error("no pin reset");
    short_pulse_a: assert property (low_cnt == RST_CYCLES && $past(core_reset_n) |-> core_reset_n)
        else $error("early pin reset");
    port_tristate_a: assert property (!core_reset_n || !ext_reset_n |-> port_oe == '0) else $error("oe");
    jtag_pullup_a: assert property (jtag_enable |->
        &{port_pullup[`SMRC_TDI_BIT], port_pullup[`SMRC_TMS_BIT], port_pullup[`SMRC_TCK_BIT]}) else $error("pu");
endmodule
bind smrc_top smrc_top_chk #(.PORT_W(PORT_W), .RST_CYCLES(RST_CYCLES)) chk_i (.clk(clk), .arst_n(arst_n),
    .ext_reset_n(ext_reset_n), .sleep_enable(sleep_enable), .sleep_mode(sleep_mode), .sleep_req(sleep_req),
    .wake_irq(wake_irq), .jtag_enable(jtag_enable), .port_oe(port_oe), .port_pullup(port_pullup),
    .gates(gates), .cpu_run(cpu_run), .sleeping(sleeping), .active_mode(active_mode), .core_reset_n(core_reset_n));

//--- bench/smrc_core_model.sv
// Behavioural processor core that issues the sleep instruction
`timescale 1ns/100ps
module smrc_core_model (
    input wire logic cpu_run,
    input wire logic cpu_clk_en,
    input wire logic exec_sleep,
    output logic sleep_req
);
    // A halted core executes nothing, so a sleep instruction needs a live clock
    assign sleep_req = exec_sleep && cpu_run && cpu_clk_en;
endmodule

//--- bench/smrc_top_test.sv
// Self-checking bench for the sleep and reset controller
`timescale 1ns/100ps
`include "smrc_consts.svh"
module smrc_top_test;
    import smrc_pkg::*;
    localparam int RC = 5;
    logic clk = 0, arst_n = 0, ext_reset_n = 1, sleep_enable = 1, wake_irq = 0, jtag_enable = 0, go = 0;
    logic [2:0] sleep_mode = 3'h0;
    logic [31:0] oe_req = 32'ha5c3_0f96, pu_req = 32'h0000_00ff, port_oe, port_pullup;
    logic cpu_run, sleeping, core_reset_n, sleep_req;
    logic [2:0] active_mode;
    smrc_gates_t gates;
    int n_fail = 0, samples_checked = 0;
    // Rows hold {mode, expected gates}
    logic [7:0] rows [6] = '{8'h0f, 8'h27, 8'h40, 8'h62, 8'hc1, 8'he3};
    smrc_top #(.RST_CYCLES(RC)) DUT (.clk(clk), .arst_n(arst_n), .ext_reset_n(ext_reset_n),
        .sleep_enable(sleep_enable), .sleep_mode(sleep_mode), .sleep_req(sleep_req), .wake_irq(wake_irq),
        .jtag_enable(jtag_enable), .port_oe_req(oe_req), .port_pullup_req(pu_req), .port_oe(port_oe),
        .port_pullup(port_pullup), .gates(gates), .cpu_run(cpu_run), .sleeping(sleeping),
        .active_mode(active_mode), .core_reset_n(core_reset_n));
    smrc_core_model core (.cpu_run(cpu_run), .cpu_clk_en(gates.cpu), .exec_sleep(go), .sleep_req(sleep_req));
    always #5 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One sleep instruction, issued for exactly one cycle
    task automatic do_sleep(input logic [2:0] m);
        sleep_mode = m;
        go = 1;
        @(negedge clk);
        go = 0;
    endtask
    task final_report;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Whole run is under a hundred cycles
    initial begin
        #20000;
        n_fail++;
        final_report;
    end
    initial begin
        repeat (8) @(negedge clk);
        arst_n = 1;
        repeat (3) @(negedge clk);
        chk(core_reset_n, 32'h1);
        chk(port_oe, oe_req);
        chk(port_pullup, pu_req);
        // Every mode: entry, holding, then the two-step wake
        for (int i = 0; i < 6; i++) begin
            do_sleep(rows[i][7:5]);
            chk({sleeping, cpu_run, active_mode, gates}, {2'b10, rows[i]});
            repeat (3) @(negedge clk);
            chk({sleeping, cpu_run, active_mode, gates}, {2'b10, rows[i]});
            wake_irq = 1;
            @(negedge clk);
            wake_irq = 0;
            chk({sleeping, cpu_run, gates}, {2'b00, 5'h1f});
            @(negedge clk);
            chk(cpu_run, 1);
        end
        // Unused encodings and a disabled sleep are ignored
        for (int j = 0; j < 3; j++) begin
            sleep_enable = (j != 2);
            do_sleep(j < 2 ? 3'(4 + j) : 3'h2);
            chk({sleeping, gates}, 6'h1f);
            @(negedge clk);
        end
        sleep_enable = 1;
        jtag_enable = 1;
        // Pin pulses one sample short and just long enough, each hitting power-down
        for (int n = RC; n <= RC + 1; n++) begin
            do_sleep(3'h2);
            ext_reset_n = 0;
            #1;
            chk(port_oe, 0);
            chk(port_pullup, 32'h002c_0000);
            repeat (n) @(negedge clk);
            chk(core_reset_n, n > RC ? 32'h0 : 32'h1);
            ext_reset_n = 1;
            @(negedge clk);
            chk({core_reset_n, sleeping}, n > RC ? 2'b10 : 2'b11);
        end
        chk({sleeping, gates}, 6'h1f);
        // System reset arrives between edges while asleep
        do_sleep(3'h7);
        #2 arst_n = 0;
        #1;
        chk(port_oe, 32'h0);
        chk(core_reset_n, 32'h0);
        chk({sleeping, cpu_run, active_mode, gates}, 10'h11f);
        chk(port_pullup, 32'h002c_0000);
        @(negedge clk);
        arst_n = 1;
        repeat (3) @(negedge clk);
        chk(core_reset_n, 1);
        final_report;
    end
endmodule
